// file: verilog/ssf_startup_ctrl.sv
// start-up sequencer with timeout fault response and its command registers
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - hold a 16-bit output-ok assert threshold, unsigned, exponent -12 volts.
// - hold a separate 16-bit output-ok deassert threshold, same scaling.
// - after enable, wait the programmed turn-on delay in milliseconds.
// - then ramp the output over the programmed rise time in milliseconds.
// - flag a timeout when the output misses the undervoltage limit in time.
// - a zero timeout limit disables the timeout; keep trying indefinitely.
// - response 00 ignores the timeout fault and keeps operating.
// - response 01 keeps running for the delay, then follows the retry setting if still faulty.
// - response 10 disables the output at once, then follows the retry setting.
// - response 11 holds the output off while faulty, resumes once cleared.
// - retry code 000 makes no restart; output stays off until cleared.
// - retry codes 001 to 100 give one to four attempts, then latch off.
// - attempt starts are spaced by two to the delay field value times the time unit.
// - retry codes 101 and 110 give five and six attempts, then latch off.
// - retry code 111 retries without limit until commanded off.
// - delay field encodes two to the field value time units.
module ssf_startup_ctrl #(
  parameter int MS_CYCLES = ssf_pkg::MS_CYCLES_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic fault_clear_i,
  input wire logic [15:0] vout_i,
  input wire logic [15:0] uv_fault_limit_i,
  input wire logic [7:0] time_unit_ms_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic [15:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic cmd_ack_o,
  output logic out_enable_o,
  output logic ramp_active_o,
  output logic output_ok_flag_o,
  output logic startup_fault_o,
  output logic [2:0] attempt_count_o
);
  import ssf_pkg::*;

  // command registers
  logic [15:0] ok_assert_thr_q;
  logic [15:0] ok_deassert_thr_q;
  logic [15:0] turn_on_wait_time_q;
  logic [15:0] turn_on_ramp_time_q;
  logic [15:0] startup_timeout_limit_q;
  logic [7:0] startup_timeout_action_q;

  // sequencer state and timers
  ssf_state_t state_q;
  ssf_state_t state_d;
  logic [MS_W-1:0] elapsed_q;
  logic [MS_W-1:0] to_ms_q;
  logic [2:0] attempts_q;
  logic out_en_q;
  logic ms_tick;
  logic fault_cond;
  logic timeout_hit;
  logic [1:0] mode;
  logic [2:0] retries;
  logic [MS_W-1:0] fault_dly_ms;
  logic retry_left;
  ssf_state_t retry_target;

  // fault delay length: unit times two to the field value
  function automatic logic [MS_W-1:0] fault_delay(input logic [7:0] unit_ms, input logic [2:0] code);
    fault_delay = MS_W'(unit_ms) << code;
  endfunction : fault_delay

  // true for the states in which the output is driven
  function automatic logic output_driven(input ssf_state_t st);
    output_driven = (st == ST_RAMP) || (st == ST_RUN) || (st == ST_FAULT_RUN);
  endfunction : output_driven

  ssf_ms_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .tick_o(ms_tick)
  );

  ssf_ok_hyst u_ok (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .out_on_i(out_en_q),
    .vout_i(vout_i),
    .assert_thr_i(ok_assert_thr_q),
    .deassert_thr_i(ok_deassert_thr_q),
    .ok_o(output_ok_flag_o)
  );

  // command register writes; unknown codes leave everything alone
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ok_assert_thr_q <= RST_OK_ASSERT_THR;
      ok_deassert_thr_q <= RST_OK_DEASSERT_THR;
      turn_on_wait_time_q <= RST_TURN_ON_WAIT;
      turn_on_ramp_time_q <= RST_TURN_ON_RAMP;
      startup_timeout_limit_q <= RST_STARTUP_LIMIT;
      startup_timeout_action_q <= RST_STARTUP_ACTION;
    end else if (cmd_wr_i) begin
      if (cmd_code_i == CMD_OK_ASSERT_THR) begin
        ok_assert_thr_q <= cmd_wdata_i;
      end else if (cmd_code_i == CMD_OK_DEASSERT_THR) begin
        ok_deassert_thr_q <= cmd_wdata_i;
      end else if (cmd_code_i == CMD_TURN_ON_WAIT) begin
        turn_on_wait_time_q <= cmd_wdata_i;
      end else if (cmd_code_i == CMD_TURN_ON_RAMP) begin
        turn_on_ramp_time_q <= cmd_wdata_i;
      end else if (cmd_code_i == CMD_STARTUP_LIMIT) begin
        startup_timeout_limit_q <= cmd_wdata_i;
      end else if (cmd_code_i == CMD_STARTUP_ACTION) begin
        startup_timeout_action_q <= cmd_wdata_i[ACTION_W-1:0];
      end
    end
  end

  // read answer one cycle after the request; unknown codes read zero, no ack
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd_rdata_o <= '0;
      cmd_rvalid_o <= 1'b0;
      cmd_ack_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_rd_i;
      cmd_ack_o <= 1'b0;
      cmd_rdata_o <= '0;
      if (cmd_rd_i) begin
        cmd_ack_o <= 1'b1;
        if (cmd_code_i == CMD_OK_ASSERT_THR) begin
          cmd_rdata_o <= ok_assert_thr_q;
        end else if (cmd_code_i == CMD_OK_DEASSERT_THR) begin
          cmd_rdata_o <= ok_deassert_thr_q;
        end else if (cmd_code_i == CMD_TURN_ON_WAIT) begin
          cmd_rdata_o <= turn_on_wait_time_q;
        end else if (cmd_code_i == CMD_TURN_ON_RAMP) begin
          cmd_rdata_o <= turn_on_ramp_time_q;
        end else if (cmd_code_i == CMD_STARTUP_LIMIT) begin
          cmd_rdata_o <= startup_timeout_limit_q;
        end else if (cmd_code_i == CMD_STARTUP_ACTION) begin
          cmd_rdata_o <= {8'h00, startup_timeout_action_q};
        end else begin
          cmd_ack_o <= 1'b0;
        end
      end
    end
  end

  // action fields and fault decode
  assign mode = startup_timeout_action_q[ACT_MODE_HI:ACT_MODE_LO];
  assign retries = startup_timeout_action_q[ACT_RETRY_HI:ACT_RETRY_LO];
  // delay and spacing length in milliseconds
  assign fault_dly_ms = fault_delay(time_unit_ms_i, startup_timeout_action_q[ACT_DELAY_HI:ACT_DELAY_LO]);
  assign fault_cond = vout_i < uv_fault_limit_i;
  // timeout only while powering up and only with a nonzero limit
  assign timeout_hit = (startup_timeout_limit_q != 16'h0000) && fault_cond &&
                       (to_ms_q >= MS_W'(startup_timeout_limit_q)) &&
                       ((state_q == ST_WAIT_ON) || (state_q == ST_RAMP));
  // attempts left under the retry code
  assign retry_left = (retries == RETRY_FOREVER) ||
                      ((retries != RETRY_NONE) && (attempts_q < retries));
  assign retry_target = retry_left ? ST_RETRY_WAIT : ST_LATCHED_OFF;

  // next-state logic; dropping enable always wins
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (enable_i) begin
          state_d = ST_WAIT_ON;
        end
      end
      ST_WAIT_ON: begin
        if (timeout_hit && (mode == MODE_RUN_THEN_RETRY)) begin
          state_d = ST_FAULT_RUN;
        end else if (timeout_hit && (mode == MODE_DISABLE_RETRY)) begin
          state_d = retry_target;
        end else if (timeout_hit && (mode == MODE_RESUME_WHEN_OK)) begin
          state_d = ST_HOLD_OFF;
        end else if (elapsed_q >= MS_W'(turn_on_wait_time_q)) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (timeout_hit && (mode == MODE_RUN_THEN_RETRY)) begin
          state_d = ST_FAULT_RUN;
        end else if (timeout_hit && (mode == MODE_DISABLE_RETRY)) begin
          state_d = retry_target;
        end else if (timeout_hit && (mode == MODE_RESUME_WHEN_OK)) begin
          state_d = ST_HOLD_OFF;
        // ramp ends; an ignored fault does not stop operation
        end else if ((elapsed_q >= MS_W'(turn_on_ramp_time_q)) && (!fault_cond || timeout_hit)) begin
          state_d = ST_RUN;
        end
      end
      ST_FAULT_RUN: begin
        // keep running for the delay, then judge the fault again
        if (elapsed_q >= fault_dly_ms) begin
          state_d = fault_cond ? retry_target : ST_RUN;
        end
      end
      ST_RETRY_WAIT: begin
        if (elapsed_q >= fault_dly_ms) begin
          state_d = ST_WAIT_ON;
        end
      end
      ST_HOLD_OFF: begin
        // resume once the condition is gone
        if (!fault_cond) begin
          state_d = ST_WAIT_ON;
        end
      end
      ST_LATCHED_OFF: begin
        // stay off until the fault is cleared
        if (fault_clear_i) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    if (!enable_i) begin
      state_d = ST_OFF;
    end
  end

  // state register and the output enable that follows it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= ST_OFF;
      out_en_q <= 1'b0;
      ramp_active_o <= 1'b0;
    end else begin
      state_q <= state_d;
      out_en_q <= output_driven(state_d);
      ramp_active_o <= (state_d == ST_RAMP);
    end
  end
  assign out_enable_o = out_en_q;

  // time in the current state, in whole milliseconds, saturating
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      elapsed_q <= '0;
    end else if (state_d != state_q) begin
      elapsed_q <= '0;
    end else if (ms_tick && (elapsed_q != {MS_W{1'b1}})) begin
      elapsed_q <= elapsed_q + 1'b1;
    end
  end

  // power-up time of the current attempt; restarts at each attempt
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      to_ms_q <= '0;
    end else if ((state_d == ST_WAIT_ON) && (state_q != ST_WAIT_ON)) begin
      to_ms_q <= '0;
    end else if (ms_tick && (to_ms_q != {MS_W{1'b1}}) &&
                 ((state_q == ST_WAIT_ON) || (state_q == ST_RAMP))) begin
      to_ms_q <= to_ms_q + 1'b1;
    end
  end

  // attempt counter; saturates so endless retry cannot wrap
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      attempts_q <= '0;
    end else if (!enable_i || fault_clear_i) begin
      attempts_q <= '0;
    end else if ((state_q == ST_RETRY_WAIT) && (state_d == ST_WAIT_ON) && (attempts_q != 3'h7)) begin
      attempts_q <= attempts_q + 1'b1;
    end
  end
  assign attempt_count_o = attempts_q;

  // sticky timeout flag; a new timeout beats a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      startup_fault_o <= 1'b0;
    end else if (timeout_hit) begin
      startup_fault_o <= 1'b1;
    end else if (fault_clear_i) begin
      startup_fault_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_ok_assert: assert property ((out_en_q && vout_i >= ok_assert_thr_q) |=> output_ok_flag_o)
    else $error("output ok not raised at assert threshold");
  a_ok_deassert: assert property ((out_en_q && vout_i <= ok_deassert_thr_q && vout_i < ok_assert_thr_q)
    |=> !output_ok_flag_o)
    else $error("output ok not dropped at deassert threshold");
  a_ok_hold: assert property ((out_en_q && $past(out_en_q) && vout_i < ok_assert_thr_q && vout_i > ok_deassert_thr_q)
    |=> output_ok_flag_o == $past(output_ok_flag_o))
    else $error("output ok changed inside hysteresis band");
  a_wait_hold: assert property ((state_q == ST_WAIT_ON && enable_i && !timeout_hit &&
    elapsed_q < MS_W'(turn_on_wait_time_q)) |=> !out_enable_o)
    else $error("output enabled before turn-on delay");
  a_ramp_hold: assert property ((state_q == ST_RAMP && enable_i && !timeout_hit &&
    elapsed_q < MS_W'(turn_on_ramp_time_q)) |=> ramp_active_o && out_enable_o)
    else $error("ramp ended before rise time");
  a_fault_flag: assert property (timeout_hit |=> startup_fault_o)
    else $error("timeout not flagged");
  a_no_limit: assert property ((startup_timeout_limit_q == 16'h0000 && !startup_fault_o) |=> !startup_fault_o)
    else $error("timeout flagged with limit zero");
  a_ignore_runs: assert property ((state_q == ST_RAMP && timeout_hit && mode == MODE_IGNORE && enable_i)
    |=> out_enable_o)
    else $error("ignored fault interrupted output");
  a_run_delay: assert property ((state_q == ST_RAMP && timeout_hit && mode == MODE_RUN_THEN_RETRY && enable_i)
    |=> state_q == ST_FAULT_RUN && out_enable_o)
    else $error("delayed response did not keep running");
  a_disable_now: assert property ((timeout_hit && mode == MODE_DISABLE_RETRY && enable_i) |=> !out_enable_o)
    else $error("output not disabled at once");
  a_resume_ok: assert property ((state_q == ST_HOLD_OFF && !fault_cond && enable_i) |=> state_q == ST_WAIT_ON)
    else $error("no resume after fault cleared");
  a_latched: assert property ((state_q == ST_LATCHED_OFF && enable_i && !fault_clear_i)
    |=> state_q == ST_LATCHED_OFF && !out_enable_o)
    else $error("latched off state left without clear");
  a_attempt_cap: assert property ((state_q == ST_RETRY_WAIT && retries != RETRY_FOREVER)
    |-> attempts_q < retries)
    else $error("retry beyond programmed count");
  a_retry_space: assert property ((state_q == ST_RETRY_WAIT && enable_i && elapsed_q < fault_dly_ms)
    |=> state_q == ST_RETRY_WAIT)
    else $error("retry started before spacing elapsed");
  a_attempt_reset: assert property ((!enable_i || fault_clear_i) |=> attempts_q == 3'h0)
    else $error("attempt counter not reset");

endmodule : ssf_startup_ctrl
`default_nettype wire

// file: verilog/ssf_pkg.sv
// package: command codes, field layout, reset values, timing constants and states
package ssf_pkg;

  // command codes of the start-up register set
  localparam logic [7:0] CMD_OK_ASSERT_THR = 8'h5E;
  localparam logic [7:0] CMD_OK_DEASSERT_THR = 8'h5F;
  localparam logic [7:0] CMD_TURN_ON_WAIT = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RAMP = 8'h61;
  localparam logic [7:0] CMD_STARTUP_LIMIT = 8'h62;
  localparam logic [7:0] CMD_STARTUP_ACTION = 8'h63;

  // register widths
  localparam int WORD_W = 16;
  localparam int ACTION_W = 8;
  localparam int MS_W = 17;

  // action byte field layout
  localparam int ACT_MODE_HI = 7;
  localparam int ACT_MODE_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;

  // response mode codes
  localparam logic [1:0] MODE_IGNORE = 2'h0;
  localparam logic [1:0] MODE_RUN_THEN_RETRY = 2'h1;
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] MODE_RESUME_WHEN_OK = 2'h3;

  // retry codes
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // values after reset
  localparam logic [15:0] RST_OK_ASSERT_THR = 16'h0000;
  localparam logic [15:0] RST_OK_DEASSERT_THR = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_WAIT = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_RAMP = 16'h0000;
  localparam logic [15:0] RST_STARTUP_LIMIT = 16'h0000;
  localparam logic [7:0] RST_STARTUP_ACTION = 8'h00;

  // one millisecond at the 100 MHz system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES_DEFAULT = MS_TIME_NS / CLK_PERIOD_NS;

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_ON,
    ST_RAMP,
    ST_RUN,
    ST_FAULT_RUN,
    ST_RETRY_WAIT,
    ST_HOLD_OFF,
    ST_LATCHED_OFF
  } ssf_state_t;

endpackage : ssf_pkg

// file: verilog/ssf_ms_tick.sv
// millisecond tick generator from the system clock
`timescale 1ns/100ps
`default_nettype none
module ssf_ms_tick #(
  parameter int MS_CYCLES = ssf_pkg::MS_CYCLES_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  output logic tick_o
);
  import ssf_pkg::*;

  logic [MS_W-1:0] div_q;

  // free-running divider; one pulse per millisecond
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      div_q <= '0;
      tick_o <= 1'b0;
    end else if (div_q == MS_W'(MS_CYCLES - 1)) begin
      div_q <= '0;
      tick_o <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule : ssf_ms_tick
`default_nettype wire

// file: verilog/ssf_ok_hyst.sv
// output-ok comparator with separate assert and deassert thresholds
`timescale 1ns/100ps
`default_nettype none
module ssf_ok_hyst (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic out_on_i,
  input wire logic [15:0] vout_i,
  input wire logic [15:0] assert_thr_i,
  input wire logic [15:0] deassert_thr_i,
  output logic ok_o
);
  import ssf_pkg::*;

  // hysteresis: between the two thresholds the flag keeps its value
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ok_o <= 1'b0;
    end else if (!out_on_i) begin
      ok_o <= 1'b0; // no good output while disabled
    end else if (vout_i >= assert_thr_i) begin
      ok_o <= 1'b1;
    end else if (vout_i <= deassert_thr_i) begin
      ok_o <= 1'b0;
    end
  end

endmodule : ssf_ok_hyst
`default_nettype wire

// file: dv/ssf_power_model.sv
// behavioural model of the power stage that the sequencer switches
`timescale 1ns/100ps
`default_nettype none
module ssf_power_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic out_enable_i,
  input wire logic shared_rail_i,
  input wire logic [15:0] level_i,
  output logic [15:0] vout_o
);
  // rail shows the bench level while driven here or by a paralleled source, else it collapses
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vout_o <= 16'h0000;
    end else begin
      vout_o <= (out_enable_i || shared_rail_i) ? level_i : 16'h0000;
    end
  end
endmodule : ssf_power_model
`default_nettype wire

// file: dv/test_startup_sequence_fault_response.sv
// self-checking bench for the start-up sequencer and its timeout response
`timescale 1ns/100ps
`default_nettype none
module test_startup_sequence_fault_response;
  import ssf_pkg::*;
  localparam int MSC = 4;
  localparam int CYCLE_LIMIT = 20000;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic enable_i = 1'b0;
  logic fault_clear_i = 1'b0;
  logic shared_rail = 1'b0;
  logic [15:0] level = 16'h4000;
  logic [15:0] vout;
  logic [15:0] uv_limit = 16'h0800;
  logic [7:0] time_unit = 8'h01;
  logic cmd_wr_i = 1'b0;
  logic cmd_rd_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic [15:0] cmd_rdata_o;
  logic cmd_rvalid_o;
  logic cmd_ack_o;
  logic out_enable_o;
  logic ramp_active_o;
  logic output_ok_flag_o;
  logic startup_fault_o;
  logic [2:0] attempt_count_o;
  int n_fail = 0;
  int samples_checked = 0;
  int cycle_count = 0;
  int rises;
  int gap;
  int n;
  logic on_after;
  logic [15:0] hyst_lvl [4] = '{16'h2800, 16'h1000, 16'h2800, 16'h3000};
  logic hyst_ok [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  // short millisecond keeps every timed path within a few hundred cycles
  ssf_startup_ctrl #(.MS_CYCLES(MSC)) ssf_startup_ctrl_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .enable_i(enable_i), .fault_clear_i(fault_clear_i),
    .vout_i(vout), .uv_fault_limit_i(uv_limit), .time_unit_ms_i(time_unit),
    .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o), .cmd_ack_o(cmd_ack_o),
    .out_enable_o(out_enable_o), .ramp_active_o(ramp_active_o), .output_ok_flag_o(output_ok_flag_o),
    .startup_fault_o(startup_fault_o), .attempt_count_o(attempt_count_o)
  );

  ssf_power_model ssf_power_model_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .out_enable_i(out_enable_o),
    .shared_rail_i(shared_rail), .level_i(level), .vout_o(vout)
  );

  // free-running clock
  always #5 clk_sys_i = ~clk_sys_i;

  // hang guard
  always @(posedge clk_sys_i) begin
    cycle_count++;
    if (cycle_count == CYCLE_LIMIT) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_sys_i);
    cmd_wr_i = 1'b1;
    cmd_code_i = code;
    cmd_wdata_i = data;
    @(negedge clk_sys_i);
    cmd_wr_i = 1'b0;
  endtask : wr

  // answer stands for exactly the cycle after the strobe
  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic ack);
    @(negedge clk_sys_i);
    cmd_rd_i = 1'b1;
    cmd_code_i = code;
    @(negedge clk_sys_i);
    cmd_rd_i = 1'b0;
    check("read valid", 16'(cmd_rvalid_o), 16'h0001);
    check("read ack", 16'(cmd_ack_o), 16'(ack));
    check("read data", cmd_rdata_o, exp);
  endtask : rd

  // off and cleared first, so every start begins from a fresh budget
  task automatic restart(input logic [7:0] action);
    @(negedge clk_sys_i);
    enable_i = 1'b0;
    fault_clear_i = 1'b1;
    @(negedge clk_sys_i);
    fault_clear_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check("attempts cleared", 16'(attempt_count_o), 16'h0000);
    wr(CMD_STARTUP_ACTION, {8'h00, action});
    @(negedge clk_sys_i);
    enable_i = 1'b1;
  endtask : restart

  // counts output turn-ons, last off-to-on gap and output state just after the fault
  task automatic observe(input int cycles);
    int fall_t;
    int fault_t;
    logic prev;
    rises = 0;
    gap = 0;
    on_after = 1'b0;
    fall_t = 0;
    fault_t = -10;
    prev = out_enable_o;
    for (int t = 0; t < cycles; t++) begin
      @(negedge clk_sys_i);
      if (out_enable_o === 1'b1 && prev === 1'b0) begin
        rises++;
        gap = t - fall_t;
      end
      if (out_enable_o === 1'b0 && prev === 1'b1) fall_t = t;
      if (startup_fault_o === 1'b1 && fault_t < 0) fault_t = t;
      if (t == fault_t + 2) on_after = out_enable_o;
      prev = out_enable_o;
    end
  endtask : observe

  task automatic run_case(input logic [7:0] action, input int cycles, input int exp_rises,
                          input logic exp_on, input logic exp_after, input int exp_att);
    restart(action);
    observe(cycles);
    check("timeout flag", 16'(startup_fault_o), 16'h0001);
    check("turn-on count", 16'(rises), 16'(exp_rises));
    check("output at end", 16'(out_enable_o), 16'(exp_on));
    check("output after fault", 16'(on_after), 16'(exp_after));
    check("attempts done", 16'(attempt_count_o), 16'(exp_att));
  endtask : run_case

  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(CMD_OK_ASSERT_THR + 8'(i), 16'h0000, 1'b1);
      wr(CMD_OK_ASSERT_THR + 8'(i), 16'hA5C0 + 16'(i));
      rd(CMD_OK_ASSERT_THR + 8'(i), (i == 5) ? 16'h00C5 : 16'hA5C0 + 16'(i), 1'b1);
    end
    rd(8'h64, 16'h0000, 1'b0);
    wr(CMD_OK_ASSERT_THR, 16'h3000);
    wr(CMD_OK_DEASSERT_THR, 16'h2000);
    wr(CMD_TURN_ON_WAIT, 16'h0002);
    wr(CMD_TURN_ON_RAMP, 16'h0001);
    wr(CMD_STARTUP_LIMIT, 16'h000A);
    restart(8'h00);
    n = 0;
    while (out_enable_o !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("turn-on wait", 16'(n >= 4 && n <= 13), 16'h0001);
    check("ramping", 16'(ramp_active_o), 16'h0001);
    repeat (12) @(negedge clk_sys_i);
    check("ramp done", 16'(ramp_active_o), 16'h0000);
    check("no timeout", 16'(startup_fault_o), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      level = hyst_lvl[i];
      repeat (4) @(negedge clk_sys_i);
      check("output ok", 16'(output_ok_flag_o), 16'(hyst_ok[i]));
    end
    // failing rail for the timeout cases, no wait and no ramp
    level = 16'h0000;
    wr(CMD_TURN_ON_WAIT, 16'h0000);
    wr(CMD_TURN_ON_RAMP, 16'h0000);
    wr(CMD_STARTUP_LIMIT, 16'h0000);
    restart(8'h80);
    observe(200);
    check("unlimited start", 16'(startup_fault_o), 16'h0000);
    check("still trying", 16'(out_enable_o), 16'h0001);
    wr(CMD_STARTUP_LIMIT, 16'h0002);
    run_case(8'h00, 200, 1, 1'b1, 1'b1, 0);
    run_case(8'h80, 200, 1, 1'b0, 1'b0, 0);
    // clear with enable still high leaves the latched-off state and starts afresh
    fault_clear_i = 1'b1;
    @(negedge clk_sys_i);
    fault_clear_i = 1'b0;
    check("flag cleared", 16'(startup_fault_o), 16'h0000);
    observe(20);
    check("restart after clear", 16'(rises), 16'h0001);
    for (int k = 1; k < 7; k++) begin
      run_case(8'h80 | 8'(k << 3), 400, k + 1, 1'b0, 1'b0, k);
    end
    run_case(8'h4A, 400, 2, 1'b0, 1'b1, 1);
    run_case(8'hC0, 100, 1, 1'b0, 1'b0, 0);
    shared_rail = 1'b1;
    level = 16'h4000;
    observe(40);
    check("resumed", 16'(rises), 16'h0001);
    shared_rail = 1'b0;
    level = 16'h0000;
    restart(8'hB8);
    observe(400);
    check("endless retry", 16'(rises >= 10), 16'h0001);
    enable_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check("commanded off", 16'(out_enable_o), 16'h0000);
    time_unit = 8'h02;
    restart(8'h8A);
    observe(200);
    check("retry spacing", 16'(gap >= 28 && gap <= 40), 16'h0001);
    check("spaced turn-ons", 16'(rises), 16'h0002);
    final_report();
  end
endmodule : test_startup_sequence_fault_response
`default_nettype wire
